// >>> rtl/ccc_card.sv
// channel card control logic with an axi4-lite status and control port
`timescale 1ns/100ps
module ccc_card
  import ccc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              write_strobe_low,
  input  wire logic [PAR_W-1:0]  parameter_address,
  input  wire logic [DATA_W-1:0] audio_data_bus,
  input  wire logic              channel_select_low,
  input  wire logic              drawer_select_low,
  input  wire logic              erase_pulse,
  input  wire logic              bias_pulse,
  input  wire logic              erase_ramp_clk,
  input  wire logic              bias_ramp_clk,
  output logic [5:0]             cmd_enable_low,
  output logic [DATA_W-1:0]      res_ctrl_data,
  output logic [DATA_W-1:0]      latch_a,
  output logic [DATA_W-1:0]      latch_b,
  output logic [DATA_W-1:0]      latch_c,
  output logic [ENV_W-1:0]       erase_env,
  output logic [ENV_W-1:0]       bias_env,
  output logic                   erase_drive_on,
  output logic                   bias_drive_on,
  output logic                   safety_relay,
  output logic                   nr_relay,
  output logic                   dim_out,
  output logic [1:0]             monitor_sel,
  output logic                   repro_sync_relay,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PIN_W-1:0]  s1, s2, s3, pin;
    logic [5:0]        cmd_n;
    logic [DATA_W-1:0] res, la, lb, lc;
    logic              dir_e, dir_b;
    logic [ENV_W-1:0]  env_e, env_b;
    logic              drv_e, drv_b, relay, nr, dim;
    logic [1:0]        mon;
    logic              rsel, gdim;
    logic [7:0]        awaddr;
    logic              aw_got, w_got;
    logic [31:0]       wdata;
    logic              wstb0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
  } ccc_state_t;

  ccc_state_t q, d;

  logic [PIN_W-1:0]  in_vec;
  logic              stb_n, sel_n, ep, bp, eclk, bclk;
  logic              ep_q, bp_q, eclk_q, bclk_q;
  logic [PAR_W-1:0]  par;
  logic [DATA_W-1:0] dat;
  logic              take, arm, estep, bstep;

  assign in_vec = {write_strobe_low, parameter_address, audio_data_bus, channel_select_low,
                   drawer_select_low, erase_pulse, bias_pulse, erase_ramp_clk, bias_ramp_clk};
  assign {stb_n, par, dat, sel_n} = {q.pin[23:6], q.pin[5] | q.pin[4]};
  assign {ep_q, bp_q, eclk_q, bclk_q} = q.pin[3:0];

  always_comb begin
    d = q;
    // ------------------------------------------------------------
    // pin sampling: a bit counts once stages two and three agree
    // ------------------------------------------------------------
    d.s1  = in_vec;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.pin = (q.s2 & q.s3) | (q.pin & (q.s2 | q.s3));
    {ep, bp, eclk, bclk} = d.pin[3:0];

    // ------------------------------------------------------------
    // parameter decode and latching
    // ------------------------------------------------------------
    take = !stb_n && !sel_n;
    for (int i = 0; i < 6; i++) begin
      d.cmd_n[i] = !(take && par == PAR_MON_CAL + PAR_W'(i));
    end
    if (take) begin
      if (par <= PAR_GAP_COMP) d.res = dat;
      if (par == PAR_LATCH_A) d.la = dat;
      if (par == PAR_LATCH_B) d.lb = dat;
      if (par == PAR_LATCH_C) d.lc = dat;
    end

    // ------------------------------------------------------------
    // ramp control: pulse rise starts ramp up, fall starts ramp down
    // ------------------------------------------------------------
    arm = q.la[LA_REC_ARM];
    if (ep && !ep_q && arm) d.dir_e = 1'b1;
    else if (!ep) d.dir_e = 1'b0;
    if (bp && !bp_q && arm) d.dir_b = 1'b1;
    else if (!bp) d.dir_b = 1'b0;
    estep = eclk && !eclk_q;
    bstep = bclk && !bclk_q;
    if (estep) begin
      if (q.dir_e && q.env_e != ENV_FULL) d.env_e = q.env_e + 4'h1;
      else if (!q.dir_e && q.env_e != ENV_ZERO) d.env_e = q.env_e - 4'h1;
    end
    if (bstep) begin
      if (q.dir_b && q.env_b != ENV_FULL) d.env_b = q.env_b + 4'h1;
      else if (!q.dir_b && q.env_b != ENV_ZERO) d.env_b = q.env_b - 4'h1;
    end
    // relay leads the first step: direction is set before any count moves
    d.relay = d.dir_e || d.dir_b || d.env_e != ENV_ZERO || d.env_b != ENV_ZERO;
    d.drv_e = d.dir_e && d.la[LA_REC_ARM];
    d.drv_b = d.dir_b && d.la[LA_REC_ARM];

    // ------------------------------------------------------------
    // routing, dim and noise reduction
    // ------------------------------------------------------------
    d.mon  = (d.lb[LB_MON_LO +: 2] == MON_SYNC || d.lb[LB_MON_LO +: 2] == MON_REPRO) ?
             d.lb[LB_MON_LO +: 2] : MON_INPUT;
    d.rsel = d.lb[LB_REPRO_SEL];
    d.nr   = d.lb[LB_CAL_IN] || d.la[LA_REC_ARM];
    d.dim  = (d.lb[LB_DIM] || q.gdim) && !d.la[LA_DIM_INH];

    // ------------------------------------------------------------
    // axi4-lite slave: address and data taken in either order
    // ------------------------------------------------------------
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      // strobe is kept with the data: the master may drop it once w is taken
      d.wstb0 = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_SLVERR;
      if (q.awaddr[7:2] == ADDR_CTRL[7:2]) begin
        d.bresp = RESP_OKAY;
        if (q.wstb0) d.gdim = q.wdata[0];
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (s_axi_araddr[7:2])
        ADDR_CTRL[7:2]:    d.rdata = {31'h0, q.gdim};
        ADDR_LATCH_A[7:2]: d.rdata = {24'h0, q.la};
        ADDR_LATCH_B[7:2]: d.rdata = {24'h0, q.lb};
        ADDR_LATCH_C[7:2]: d.rdata = {24'h0, q.lc};
        ADDR_STATUS[7:2]:  d.rdata = {16'h0, q.env_b, q.env_e, 1'b0, q.dim, q.nr,
                                      q.relay, q.drv_b, q.drv_e, q.dir_b, q.dir_e};
        ADDR_RES[7:2]:     d.rdata = {24'h0, q.res};
        default: begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q         <= '0;
      q.s1      <= PIN_RST;
      q.s2      <= PIN_RST;
      q.s3      <= PIN_RST;
      q.pin     <= PIN_RST;
      q.cmd_n   <= 6'h3F;
      q.la      <= LATCH_RST;
      q.lb      <= LATCH_RST;
      q.lc      <= LATCH_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmd_enable_low   = q.cmd_n;
  assign res_ctrl_data    = q.res;
  assign latch_a          = q.la;
  assign latch_b          = q.lb;
  assign latch_c          = q.lc;
  assign erase_env        = q.env_e;
  assign bias_env         = q.env_b;
  assign erase_drive_on   = q.drv_e;
  assign bias_drive_on    = q.drv_b;
  assign safety_relay     = q.relay;
  assign nr_relay         = q.nr;
  assign dim_out          = q.dim;
  assign monitor_sel      = q.mon;
  assign repro_sync_relay = q.rsel;
  assign s_axi_awready    = q.awready;
  assign s_axi_wready     = q.wready;
  assign s_axi_bresp      = q.bresp;
  assign s_axi_bvalid     = q.bvalid;
  assign s_axi_arready    = q.arready;
  assign s_axi_rdata      = q.rdata;
  assign s_axi_rresp      = q.rresp;
  assign s_axi_rvalid     = q.rvalid;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  latch_needs_strobe_a: assert property ($changed(q.la) |-> $past(take))
    else $error("latch a changed without strobe");
  cmd_needs_select_a: assert property (!(&q.cmd_n) |-> $past(!sel_n && !stb_n))
    else $error("command enable without select");
  cmd_one_hot_a: assert property ($onehot0(~q.cmd_n))
    else $error("more than one command enable");
  latch_b_load_a: assert property (take && par == PAR_LATCH_B |=> q.lb == $past(dat))
    else $error("latch b missed its data");
  latch_c_load_a: assert property (take && par == PAR_LATCH_C |=> q.lc == $past(dat))
    else $error("latch c missed its data");
  dir_needs_arm_a: assert property ($rose(q.dir_e) |-> $past(arm))
    else $error("erase ramp started without record arm");
  env_no_wrap_a: assert property (q.env_b == ENV_FULL && q.dir_b |=> q.env_b == ENV_FULL)
    else $error("bias envelope wrapped");
  env_step_clk_a: assert property ($changed(q.env_e) |-> $past(estep))
    else $error("erase envelope moved without its clock");
  drive_gate_a: assert property (q.drv_b |-> q.la[LA_REC_ARM])
    else $error("bias drive without record ready");
  relay_cover_a: assert property (q.env_e != ENV_ZERO || q.env_b != ENV_ZERO |-> q.relay)
    else $error("envelope live with relay released");
  relay_lead_a: assert property ($past(~|q.env_b) && |q.env_b |-> $past(q.relay))
    else $error("bias envelope rose before relay");
  nr_follow_a: assert property (q.la[LA_REC_ARM] |-> q.nr)
    else $error("noise reduction relay not closed on record");
  dim_global_a: assert property ($past(q.gdim) && !q.la[LA_DIM_INH] |-> q.dim)
    else $error("global dim ignored");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  ramp_full_c: cover property (q.env_e == ENV_FULL && q.env_b == ENV_FULL);
  ramp_done_c: cover property ($fell(q.relay));
  write_c:     cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  res_load_c:  cover property (!q.cmd_n[5]);
endmodule : ccc_card

// >>> rtl/ccc_pkg.sv
// constants and rule notes for the channel card control logic
//
// Notes on behaviour
// - data bus is captured into latches and resistor controls only while strobe is low.
// - parameter address decodes into six dedicated command enables.
// - command enables act only when channel and drawer selects give a low enable.
// - latch A holds gap comp, uncal selects, record arm, dim inhibit, frequency bits.
// - latch B holds repro/sync routing, dim, cal input and record/sync switching.
// - latch C holds secondary record compensation and ramp timing controls.
// - ramp direction flip-flops set only while record arm enable is active.
// - ramp clocks set step rate; direction state picks counting up or down.
// - each envelope is a 4 bit up/down count feeding a ladder converter.
// - erase counter steps on erase ramp clock, bias counter on bias ramp clock.
// - bias and erase drive blocked unless record ready enable is asserted.
// - safety relay energised before envelopes rise, released after both decay.
// - input or record command closes the noise reduction relay output.
// - dim switches off the output buffer path under processor command.
// - dim is controllable per card or globally for the whole machine.
// - output monitor selects input, repro head or sync head signal.
// - repro path source relay follows the user repro or sync selection.
package ccc_pkg;
  // ----------------------------------------------------------------
  // pin vector
  // ----------------------------------------------------------------
  localparam int PAR_W  = 9;
  localparam int DATA_W = 8;
  localparam int ENV_W  = 4;
  localparam int PIN_W  = 24;
  localparam logic [PIN_W-1:0] PIN_RST = 24'hFFFFF0;

  // ----------------------------------------------------------------
  // parameter address codes
  // ----------------------------------------------------------------
  localparam logic [PAR_W-1:0] PAR_MON_CAL  = 9'h000;
  localparam logic [PAR_W-1:0] PAR_MON_BIAS = 9'h001;
  localparam logic [PAR_W-1:0] PAR_REP_EQ   = 9'h002;
  localparam logic [PAR_W-1:0] PAR_REC_EQ   = 9'h003;
  localparam logic [PAR_W-1:0] PAR_SEC_COMP = 9'h004;
  localparam logic [PAR_W-1:0] PAR_GAP_COMP = 9'h005;
  localparam logic [PAR_W-1:0] PAR_LATCH_A  = 9'h006;
  localparam logic [PAR_W-1:0] PAR_LATCH_B  = 9'h007;
  localparam logic [PAR_W-1:0] PAR_LATCH_C  = 9'h008;

  // ----------------------------------------------------------------
  // latch field positions
  // ----------------------------------------------------------------
  localparam int LA_REC_ARM   = 3;
  localparam int LA_DIM_INH   = 4;
  localparam int LA_LOW_DEF   = 5;
  localparam int LB_REPRO_SEL = 0;
  localparam int LB_DIM       = 1;
  localparam int LB_MON_LO    = 2;
  localparam int LB_CAL_IN    = 4;
  localparam logic [1:0] MON_INPUT = 2'h0;
  localparam logic [1:0] MON_REPRO = 2'h1;
  localparam logic [1:0] MON_SYNC  = 2'h2;
  localparam logic [DATA_W-1:0] LATCH_RST = 8'h00;
  localparam logic [ENV_W-1:0]  ENV_FULL  = 4'hF;
  localparam logic [ENV_W-1:0]  ENV_ZERO  = 4'h0;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_LATCH_A = 8'h04;
  localparam logic [7:0] ADDR_LATCH_B = 8'h08;
  localparam logic [7:0] ADDR_LATCH_C = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_RES     = 8'h14;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : ccc_pkg

// >>> test/ccc_master_model.sv
// behavioural master card: parameter bus writes and ramp pulses and clocks
`timescale 1ns/100ps
module ccc_master_model
  import ccc_pkg::*;
(
  input  wire logic         core_clk,
  output logic              write_strobe_low,
  output logic [PAR_W-1:0]  parameter_address,
  output logic [DATA_W-1:0] audio_data_bus,
  output logic              channel_select_low,
  output logic              drawer_select_low,
  output logic              erase_pulse,
  output logic              bias_pulse,
  output logic              erase_ramp_clk,
  output logic              bias_ramp_clk
);
  initial begin
    write_strobe_low = 1'b1;
    parameter_address = '0;
    audio_data_bus = 8'h00;
    channel_select_low = 1'b1;
    drawer_select_low = 1'b1;
    erase_pulse = 1'b0;
    bias_pulse = 1'b0;
    erase_ramp_clk = 1'b0;
    bias_ramp_clk = 1'b0;
  end

  // -----------------------------------------------------------------
  // parameter bus: every task is entered just after a clock edge
  // -----------------------------------------------------------------
  // address and selects settle before the strobe, the card syncs through 4 flops
  task automatic put_open(input logic [PAR_W-1:0] c, input logic [DATA_W-1:0] d,
                          input logic ch, input logic dr);
    parameter_address <= c;
    audio_data_bus <= d;
    channel_select_low <= ch;
    drawer_select_low <= dr;
    repeat (6) @(posedge core_clk);
    write_strobe_low <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : put_open

  // after the hold the bus is released and shows the inverse of its last value
  task automatic put_close();
    write_strobe_low <= 1'b1;
    repeat (6) @(posedge core_clk);
    audio_data_bus <= ~audio_data_bus;
    channel_select_low <= 1'b1;
    drawer_select_low <= 1'b1;
    repeat (6) @(posedge core_clk);
  endtask : put_close

  // -----------------------------------------------------------------
  // ramp pins
  // -----------------------------------------------------------------
  task automatic pulse(input logic lvl);
    erase_pulse <= lvl;
    bias_pulse <= lvl;
    repeat (8) @(posedge core_clk);
  endtask : pulse

  // ramp clocks stand low between steps
  task automatic step(input logic e, input logic b);
    erase_ramp_clk <= e;
    bias_ramp_clk <= b;
    repeat (5) @(posedge core_clk);
    erase_ramp_clk <= 1'b0;
    bias_ramp_clk <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : step
endmodule : ccc_master_model

// >>> test/testbench.sv
// self-checking bench for the channel card control logic
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench
  import ccc_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] rs;
  logic strb_n, ch_n, dr_n, ep, bp, eclk, bclk, awrdy, wrdy, bvld, arrdy, rvld;
  logic [PAR_W-1:0] par;
  logic [7:0] db, res, la, lb, lc;
  logic [5:0] cmd_n;
  logic [3:0] eenv, benv;
  logic edrv, bdrv, relay, nr, dim, rsrel;
  logic [1:0] mon, bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  logic [1:0] mons [3] = '{MON_INPUT, MON_REPRO, MON_SYNC};
  localparam logic [7:0] ARM = 8'h01 << LA_REC_ARM;

  always #4 core_clk = ~core_clk;

  ccc_master_model mm (.core_clk(core_clk), .write_strobe_low(strb_n),
    .parameter_address(par), .audio_data_bus(db), .channel_select_low(ch_n),
    .drawer_select_low(dr_n), .erase_pulse(ep), .bias_pulse(bp),
    .erase_ramp_clk(eclk), .bias_ramp_clk(bclk));

  ccc_card dut (.core_clk(core_clk), .srst(srst), .write_strobe_low(strb_n),
    .parameter_address(par), .audio_data_bus(db), .channel_select_low(ch_n),
    .drawer_select_low(dr_n), .erase_pulse(ep), .bias_pulse(bp),
    .erase_ramp_clk(eclk), .bias_ramp_clk(bclk), .cmd_enable_low(cmd_n),
    .res_ctrl_data(res), .latch_a(la), .latch_b(lb), .latch_c(lc), .erase_env(eenv),
    .bias_env(benv), .erase_drive_on(edrv), .bias_drive_on(bdrv),
    .safety_relay(relay), .nr_relay(nr), .dim_out(dim), .monitor_sel(mon),
    .repro_sync_relay(rsrel), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awrdy), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvld), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arrdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvld), .s_axi_rready(rready));

  // -----------------------------------------------------------------
  // bus tasks, entered just after a clock edge
  // -----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awrdy) awvalid <= 1'b0;
      if (wvalid && wrdy) begin
        wvalid <= 1'b0;
        wstrb <= 4'h0;
      end
      if (bvld) break;
    end
    bready <= 1'b0;
    rs = bresp;
    @(posedge core_clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arrdy) arvalid <= 1'b0;
      if (rvld) break;
    end
    rready <= 1'b0;
    rs = rresp;
    rd = rdata;
    @(posedge core_clk);
  endtask : axi_rd

  task automatic put(input logic [PAR_W-1:0] c, input logic [7:0] d);
    mm.put_open(c, d, 1'b0, 1'b0);
    mm.put_close();
  endtask : put

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // run is about 1150 cycles, so a hang is cut well past it
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    `CHK("cmd idle", 6'h3F, cmd_n)
    for (int i = 0; i < 6; i++) begin
      mm.put_open(PAR_W'(i), 8'h3C + 8'(i), 1'b0, 1'b0);
      `CHK("cmd", ~(6'h01 << i), cmd_n)
      mm.put_close();
      `CHK("cmd off", 6'h3F, cmd_n)
      `CHK("res ctrl", 8'h3C + 8'(i), res)
    end
    for (int k = 1; k < 4; k++) begin
      mm.put_open(PAR_REP_EQ, 8'h5A, k[0], k[1]);
      `CHK("cmd unsel", 6'h3F, cmd_n)
      mm.put_close();
      `CHK("res kept", 8'h41, res)
    end
    mm.pulse(1'b1);
    mm.step(1'b1, 1'b1);
    `CHK("env no arm", 4'h0, eenv)
    `CHK("drive no arm", 1'b0, edrv)
    `CHK("relay no arm", 1'b0, relay)
    mm.pulse(1'b0);
    put(PAR_LATCH_A, ARM);
    `CHK("latch a", ARM, la)
    `CHK("nr arm", 1'b1, nr)
    mm.pulse(1'b1);
    `CHK("relay up", 1'b1, relay)
    `CHK("erase drive", 1'b1, edrv)
    `CHK("bias drive", 1'b1, bdrv)
    repeat (3) mm.step(1'b1, 1'b0);
    `CHK("erase 3", 4'h3, eenv)
    `CHK("bias 0", 4'h0, benv)
    repeat (15) mm.step(1'b1, 1'b1);
    `CHK("erase full", ENV_FULL, eenv)
    `CHK("bias full", ENV_FULL, benv)
    axi_rd(ADDR_STATUS);
    `CHK("status", 32'h0000FF3F, rd)
    mm.pulse(1'b0);
    `CHK("drive down", 1'b0, edrv)
    repeat (16) mm.step(1'b1, 1'b0);
    `CHK("erase zero", ENV_ZERO, eenv)
    `CHK("relay held", 1'b1, relay)
    repeat (14) mm.step(1'b0, 1'b1);
    `CHK("bias 1", 4'h1, benv)
    `CHK("relay held b", 1'b1, relay)
    mm.step(1'b0, 1'b1);
    `CHK("relay off", 1'b0, relay)
    put(PAR_LATCH_A, 8'h00);
    `CHK("nr off", 1'b0, nr)
    for (int m = 0; m < 3; m++) begin
      put(PAR_LATCH_B, (8'(mons[m]) << LB_MON_LO) | 8'(m % 2));
      `CHK("latch b", (8'(mons[m]) << LB_MON_LO) | 8'(m % 2), lb)
      `CHK("monitor", mons[m], mon)
      `CHK("repro relay", 1'(m % 2), rsrel)
    end
    put(PAR_LATCH_B, 8'h03 << LB_MON_LO);
    `CHK("monitor code 3", MON_INPUT, mon)
    put(PAR_LATCH_B, 8'h01 << LB_CAL_IN);
    `CHK("nr cal", 1'b1, nr)
    put(PAR_LATCH_B, 8'h01 << LB_DIM);
    `CHK("card dim", 1'b1, dim)
    put(PAR_LATCH_A, 8'h01 << LA_DIM_INH);
    `CHK("dim inhibit", 1'b0, dim)
    put(PAR_LATCH_A, 8'h00);
    put(PAR_LATCH_B, 8'h00);
    axi_wr(ADDR_CTRL, 32'h1);
    `CHK("ctrl resp", RESP_OKAY, rs)
    `CHK("global dim", 1'b1, dim)
    axi_rd(ADDR_CTRL);
    `CHK("ctrl rd", 32'h00000001, rd)
    axi_wr(ADDR_CTRL, 32'h0);
    `CHK("dim clear", 1'b0, dim)
    put(PAR_LATCH_C, 8'hA5);
    `CHK("latch c", 8'hA5, lc)
    axi_rd(ADDR_LATCH_C);
    `CHK("latch c rd", 32'h000000A5, rd)
    axi_wr(ADDR_LATCH_A, 32'hFF);
    `CHK("ro resp", RESP_SLVERR, rs)
    `CHK("ro kept", 8'h00, la)
    axi_rd(8'h1C);
    `CHK("unmapped", RESP_SLVERR, rs)
    `CHK("unmapped data", 32'h0, rd)
    axi_rd(ADDR_RES);
    `CHK("res ctrl rd", 32'h00000041, rd)
    give_verdict();
  end
endmodule : testbench
